// file: design/micint_defines.svh
// Constants of the interrupt controller.
// Operation
// - Seven request sources: two external lines, three timers, comparator, ADC.
// - Each source has its own enable bit.
// - Flags are set by hardware only; software clears them by writing zeros.
// - Edge-sensitive sources set on rising, falling or both edges per edge select.
// - Global enable gates all lines; enable and disable instructions set and clear it.
// - Flags still set while their enable bit is zero.
// - Stack lives in data memory at the stack pointer; saved counter is 16 bits.
// - Taking an interrupt saves the program counter at the stack pointer.
// - Then stack pointer plus two, global enable cleared, fetch from vector.
// - Return restores counter, stack pointer minus two, global enable set, resume.
// - The flag register is readable to identify the source.
// - Push and pop save and restore accumulator and status to stack memory.
// - Each external line picks one of two pins by a one-time option.
`ifndef MICINT_DEFINES_SVH
`define MICINT_DEFINES_SVH
`define MICINT_NSRC      7
`define MICINT_VECTOR    16'h0010
`define MICINT_SP_STEP   8'h02
`define MICINT_ADDR_FLAG 12'h000
`define MICINT_ADDR_EN   12'h004
`define MICINT_ADDR_EDGE 12'h008
`define MICINT_ADDR_SP   12'h00C
`define MICINT_ADDR_CTRL 12'h010
`define MICINT_ADDR_IST  12'h014
`define MICINT_ADDR_IMSK 12'h018
`define MICINT_EDGE_RISE 2'h0
`define MICINT_EDGE_FALL 2'h1
`define MICINT_EDGE_BOTH 2'h2
`endif

// file: design/micint_pkg.sv
// Types of the interrupt controller.
package micint_pkg;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } micint_mem_req_t;
  typedef enum logic [6:0] {
    MI_IDLE  = 7'h01,
    MI_PUSHL = 7'h02,
    MI_PUSHH = 7'h04,
    MI_POPH  = 7'h08,
    MI_POPL  = 7'h10,
    MI_PUSHA = 7'h20,
    MI_POPA  = 7'h40
  } micint_state_t;
endpackage

// file: design/micint_edge_det.sv
// Edge detector with selectable edge for one request line.
`timescale 1ns/1ps
`include "micint_defines.svh"
module micint_edge_det (
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  // Line and selection
  input  wire logic       i_line,
  input  wire logic [1:0] i_sel,
  // Event
  output logic            o_event
);
  logic prev_r;
  logic prev_nxt;
  always_comb begin
    prev_nxt = i_line;
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
    end
  end
  always_comb begin
    case (i_sel)
      `MICINT_EDGE_RISE: o_event = i_line & ~prev_r;
      `MICINT_EDGE_FALL: o_event = ~i_line & prev_r;
      default:           o_event = i_line ^ prev_r;
    endcase
  end
endmodule

// file: design/micint_ext_sel.sv
// Pin chooser for one external request line.
`timescale 1ns/1ps
module micint_ext_sel (
  // Candidate pins
  input  wire logic i_pin0,
  input  wire logic i_pin1,
  // Option
  input  wire logic i_opt,
  // Chosen line
  output logic      o_line
);
  always_comb begin
    o_line = i_opt ? i_pin1 : i_pin0;
  end
endmodule

// file: design/micint_top.sv
// Interrupt controller with APB registers and CPU vectoring sequencer.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "micint_defines.svh"
module micint_top
  import micint_pkg::*;
#(
  parameter int NSRC = `MICINT_NSRC
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [31:0]      o_prdata,
  // Request sources
  input  wire logic [1:0]  i_ext_a_pins,
  input  wire logic [1:0]  i_ext_b_pins,
  input  wire logic        i_ext_line_a_pin_option,
  input  wire logic        i_ext_line_b_pin_option,
  input  wire logic        i_wide_timer_evt,
  input  wire logic        i_second_timer_evt,
  input  wire logic        i_third_timer_evt,
  input  wire logic        i_analog_comparator_evt,
  input  wire logic        i_adc_evt,
  // CPU side
  input  wire logic        i_instr_boundary,
  input  wire logic [15:0] i_pc,
  input  wire logic        i_engint,
  input  wire logic        i_disgint,
  input  wire logic        i_reti,
  input  wire logic        i_pushaf,
  input  wire logic        i_popaf,
  input  wire logic [7:0]  i_accumulator,
  input  wire logic [7:0]  i_status,
  output logic             o_busy,
  output logic             o_pc_load,
  output logic [15:0]      o_pc_value,
  output logic             o_af_load,
  output logic [7:0]       o_accumulator,
  output logic [7:0]       o_status,
  output logic             o_global_en,
  // Data memory port
  output micint_mem_req_t  o_mem,
  output logic             o_mem_valid,
  input  wire logic [7:0]  i_mem_rdata,
  // Interrupt
  output logic             o_irq
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [NSRC-1:0]   raw;
  logic [NSRC-1:0]   evt;
  logic              ext_a;
  logic              ext_b;
  logic [NSRC-1:0]   flag_r, flag_nxt;
  logic [NSRC-1:0]   en_r, en_nxt;
  logic [2*NSRC-1:0] edge_r, edge_nxt;
  logic [7:0]        sp_r, sp_nxt;
  logic              gie_r, gie_nxt;
  logic [1:0]        ist_r, ist_nxt;
  logic [1:0]        imsk_r, imsk_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  micint_state_t     st_r, st_nxt;
  logic [7:0]        hold_r, hold_nxt;
  logic              pop_ph_r, pop_ph_nxt;
  logic              wr_acc, rd_acc, hit;
  logic              take;
  micint_ext_sel u_sel_a (
    .i_pin0 (i_ext_a_pins[0]),
    .i_pin1 (i_ext_a_pins[1]),
    .i_opt  (i_ext_line_a_pin_option),
    .o_line (ext_a)
  );
  micint_ext_sel u_sel_b (
    .i_pin0 (i_ext_b_pins[0]),
    .i_pin1 (i_ext_b_pins[1]),
    .i_opt  (i_ext_line_b_pin_option),
    .o_line (ext_b)
  );
  always_comb begin
    raw = {i_adc_evt, i_analog_comparator_evt, i_third_timer_evt, i_second_timer_evt,
           i_wide_timer_evt, ext_b, ext_a};
  end
  for (genvar g = 0; g < NSRC; g++) begin : g_edge
    micint_edge_det u_edge (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_line     (raw[g]),
      .i_sel      (edge_r[2*g +: 2]),
      .o_event    (evt[g])
    );
  end
  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    wr_acc    = i_psel & i_penable & i_pwrite;
    rd_acc    = i_psel & i_penable & ~i_pwrite;
    o_pready  = 1'b1;
    hit       = (i_paddr == `MICINT_ADDR_FLAG) | (i_paddr == `MICINT_ADDR_EN) |
                (i_paddr == `MICINT_ADDR_EDGE) | (i_paddr == `MICINT_ADDR_SP) |
                (i_paddr == `MICINT_ADDR_CTRL) | (i_paddr == `MICINT_ADDR_IST) |
                (i_paddr == `MICINT_ADDR_IMSK);
    o_pslverr = i_psel & i_penable & ~hit;
    o_prdata  = rdata_r;
  end
  always_comb begin
    take = i_instr_boundary & gie_r & |(flag_r & en_r) & (st_r == MI_IDLE);
    flag_nxt = flag_r;
    if (wr_acc && i_paddr == `MICINT_ADDR_FLAG) begin
      flag_nxt = flag_r & i_pwdata[NSRC-1:0];
    end
    flag_nxt = flag_nxt | evt;
    en_nxt   = (wr_acc && i_paddr == `MICINT_ADDR_EN) ? i_pwdata[NSRC-1:0] : en_r;
    edge_nxt = (wr_acc && i_paddr == `MICINT_ADDR_EDGE) ? i_pwdata[2*NSRC-1:0] : edge_r;
    imsk_nxt = (wr_acc && i_paddr == `MICINT_ADDR_IMSK) ? i_pwdata[1:0] : imsk_r;
    ist_nxt  = ist_r;
    if (rd_acc && i_paddr == `MICINT_ADDR_IST) begin
      ist_nxt = 2'h0;
    end
    ist_nxt = ist_nxt | {i_reti & ~take & (st_r == MI_IDLE), take};
    rdata_nxt = 32'h0;
    case (i_paddr)
      `MICINT_ADDR_FLAG: rdata_nxt[NSRC-1:0]   = flag_nxt;
      `MICINT_ADDR_EN:   rdata_nxt[NSRC-1:0]   = en_r;
      `MICINT_ADDR_EDGE: rdata_nxt[2*NSRC-1:0] = edge_r;
      `MICINT_ADDR_SP:   rdata_nxt[7:0]        = sp_r;
      `MICINT_ADDR_CTRL: rdata_nxt[0]          = gie_r;
      `MICINT_ADDR_IST:  rdata_nxt[1:0]        = ist_nxt;
      `MICINT_ADDR_IMSK: rdata_nxt[1:0]        = imsk_r;
      default:           rdata_nxt             = 32'h0;
    endcase
    o_irq = |(ist_r & imsk_r);
  end
  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt        = st_r;
    sp_nxt        = sp_r;
    gie_nxt       = gie_r;
    hold_nxt      = hold_r;
    pop_ph_nxt    = pop_ph_r;
    o_mem         = '0;
    o_mem_valid   = 1'b0;
    o_pc_load     = 1'b0;
    o_pc_value    = 16'h0000;
    o_af_load     = 1'b0;
    o_accumulator = hold_r;
    o_status      = i_mem_rdata;
    if (i_engint) begin
      gie_nxt = 1'b1;
    end
    if (i_disgint) begin
      gie_nxt = 1'b0;
    end
    if (wr_acc && i_paddr == `MICINT_ADDR_SP) begin
      sp_nxt = i_pwdata[7:0];
    end
    if (wr_acc && i_paddr == `MICINT_ADDR_CTRL) begin
      gie_nxt = i_pwdata[0];
    end
    case (st_r)
      MI_IDLE: begin
        if (take) begin
          o_mem_valid = 1'b1;
          o_mem       = '{wr: 1'b1, addr: sp_r, wdata: i_pc[7:0]};
          hold_nxt    = i_pc[15:8];
          st_nxt      = MI_PUSHL;
        end else if (i_reti) begin
          o_mem_valid = 1'b1;
          o_mem       = '{wr: 1'b0, addr: sp_r - 8'h01, wdata: 8'h00};
          st_nxt      = MI_POPH;
        end else if (i_pushaf) begin
          o_mem_valid = 1'b1;
          o_mem       = '{wr: 1'b1, addr: sp_r, wdata: i_accumulator};
          hold_nxt    = i_status;
          st_nxt      = MI_PUSHA;
        end else if (i_popaf) begin
          o_mem_valid = 1'b1;
          o_mem       = '{wr: 1'b0, addr: sp_r - 8'h02, wdata: 8'h00};
          st_nxt      = MI_POPA;
        end
      end
      MI_PUSHL: begin
        o_mem_valid = 1'b1;
        o_mem       = '{wr: 1'b1, addr: sp_r + 8'h01, wdata: hold_r};
        sp_nxt      = sp_r + `MICINT_SP_STEP;
        gie_nxt     = 1'b0;
        o_pc_load   = 1'b1;
        o_pc_value  = `MICINT_VECTOR;
        st_nxt      = MI_IDLE;
      end
      MI_PUSHA: begin
        o_mem_valid = 1'b1;
        o_mem       = '{wr: 1'b1, addr: sp_r + 8'h01, wdata: hold_r};
        sp_nxt      = sp_r + `MICINT_SP_STEP;
        st_nxt      = MI_IDLE;
      end
      MI_POPH: begin
        hold_nxt    = i_mem_rdata;
        o_mem_valid = 1'b1;
        o_mem       = '{wr: 1'b0, addr: sp_r - `MICINT_SP_STEP, wdata: 8'h00};
        st_nxt      = MI_POPL;
      end
      MI_POPL: begin
        o_pc_load  = 1'b1;
        o_pc_value = {hold_r, i_mem_rdata};
        sp_nxt     = sp_r - `MICINT_SP_STEP;
        gie_nxt    = 1'b1;
        st_nxt     = MI_IDLE;
      end
      MI_POPA: begin
        if (!pop_ph_r) begin
          hold_nxt    = i_mem_rdata;
          o_mem_valid = 1'b1;
          o_mem       = '{wr: 1'b0, addr: sp_r - 8'h01, wdata: 8'h00};
          pop_ph_nxt  = 1'b1;
        end else begin
          o_af_load     = 1'b1;
          o_accumulator = hold_r;
          o_status      = i_mem_rdata;
          sp_nxt        = sp_r - `MICINT_SP_STEP;
          pop_ph_nxt    = 1'b0;
          st_nxt        = MI_IDLE;
        end
      end
      default: begin
        st_nxt = MI_IDLE;
      end
    endcase
    o_busy      = (st_r != MI_IDLE);
    o_global_en = gie_r;
  end
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_r  <= '0;
      en_r    <= '0;
      edge_r  <= '0;
      sp_r    <= 8'h00;
      gie_r   <= 1'b0;
      ist_r   <= 2'h0;
      imsk_r  <= 2'h0;
      rdata_r <= 32'h0;
      st_r    <= MI_IDLE;
      hold_r  <= 8'h00;
      pop_ph_r <= 1'b0;
    end else begin
      flag_r  <= flag_nxt;
      en_r    <= en_nxt;
      edge_r  <= edge_nxt;
      sp_r    <= sp_nxt;
      gie_r   <= gie_nxt;
      ist_r   <= ist_nxt;
      imsk_r  <= imsk_nxt;
      rdata_r <= rdata_nxt;
      st_r    <= st_nxt;
      hold_r  <= hold_nxt;
      pop_ph_r <= pop_ph_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_entry;
    st_r == MI_PUSHL ##1 st_r == MI_IDLE;
  endsequence
  sequence s_return;
    st_r == MI_POPH ##1 (st_r == MI_POPL && o_pc_load) ##1 st_r == MI_IDLE;
  endsequence
  sequence s_pop_af;
    (st_r == MI_POPA && !pop_ph_r) ##1 (st_r == MI_POPA && o_af_load) ##1 st_r == MI_IDLE;
  endsequence

  a_set_beats_clr: assert property (@(posedge i_core_clk) disable iff (i_rst)
    evt[0] |=> flag_r[0])
    else $error("flag lost");

  a_flag_no_enable: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (evt[2] && !en_r[2]) |=> flag_r[2])
    else $error("flag not set");

  a_take_gated: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(st_r == MI_PUSHL) |-> $past(gie_r))
    else $error("entry without global enable");

  a_entry_vec: assert property (@(posedge i_core_clk) disable iff (i_rst)
    st_r == MI_PUSHL |-> o_pc_load && o_pc_value == `MICINT_VECTOR)
    else $error("vector");

  a_entry_sp: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (st_r == MI_PUSHL && !wr_acc) |=> sp_r == $past(sp_r) + `MICINT_SP_STEP && !gie_r)
    else $error("sp up");

  a_push_pc: assert property (@(posedge i_core_clk) disable iff (i_rst)
    take |-> o_mem.wr && o_mem.addr == sp_r && o_mem.wdata == i_pc[7:0])
    else $error("push");

  a_ret_sp: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (st_r == MI_POPL && !wr_acc) |=> sp_r == $past(sp_r) - `MICINT_SP_STEP && gie_r)
    else $error("sp down");

  a_take_seq: assert property (@(posedge i_core_clk) disable iff (i_rst)
    take |=> s_entry)
    else $error("entry");

  a_return_seq: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (st_r == MI_IDLE && !take && i_reti) |=> s_return)
    else $error("return sequence");

  a_pop_af_seq: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (st_r == MI_IDLE && !take && !i_reti && !i_pushaf && i_popaf) |=> s_pop_af)
    else $error("pop sequence");

  a_push_af: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (st_r == MI_IDLE && !take && !i_reti && i_pushaf) |-> o_mem_valid && o_mem.wr &&
      o_mem.addr == sp_r && o_mem.wdata == i_accumulator)
    else $error("push accumulator");

  a_return_addr: assert property (@(posedge i_core_clk) disable iff (i_rst)
    st_r == MI_POPH |-> o_mem_valid && !o_mem.wr && o_mem.addr == sp_r - `MICINT_SP_STEP)
    else $error("return address");

  a_flag_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (wr_acc && i_paddr == `MICINT_ADDR_FLAG && !i_pwdata[0] && !evt[0]) |=> !flag_r[0])
    else $error("flag not cleared");

  a_flag_hw_only: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!flag_r[1] && !evt[1]) |=> !flag_r[1])
    else $error("flag set without event");

  a_flag_keep: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (flag_r[2] && !(wr_acc && i_paddr == `MICINT_ADDR_FLAG)) |=> flag_r[2])
    else $error("flag dropped");

  a_gie_on: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_engint && !i_disgint && st_r == MI_IDLE && !wr_acc) |=> gie_r)
    else $error("global enable not set");

  a_gie_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_disgint && st_r == MI_IDLE && !wr_acc) |=> !gie_r)
    else $error("global enable not cleared");

  a_gated_idle: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (st_r == MI_IDLE && !gie_r) |=> st_r != MI_PUSHL)
    else $error("entry while globally disabled");

  a_enable_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (st_r == MI_IDLE && !(|(flag_r & en_r))) |=> st_r != MI_PUSHL)
    else $error("entry without enabled flag");

  a_entry_event: assert property (@(posedge i_core_clk) disable iff (i_rst)
    take |=> ist_r[0])
    else $error("entry event not recorded");
endmodule

// file: verif/micint_mem_model.sv
// Data memory model that answers the stack port of the controller.
`timescale 1ns/1ps
module micint_mem_model
  import micint_pkg::*;
(
  // Clock
  input  wire logic            i_core_clk,
  // Request
  input  wire micint_mem_req_t i_mem,
  input  wire logic            i_mem_valid,
  // Read data
  output logic [7:0]           o_rdata
);
  logic [7:0] mem [256];
  ////////////////////////////////////////////////////////////////////////////////
  // Read data is only good for one cycle, so it toggles whenever no read is answered.
  initial o_rdata = 8'h5A;
  always @(posedge i_core_clk) begin
    o_rdata <= ~o_rdata;
    if (i_mem_valid && i_mem.wr) begin
      mem[i_mem.addr] <= i_mem.wdata;
    end else if (i_mem_valid) begin
      o_rdata <= mem[i_mem.addr];
    end
  end
endmodule

// file: verif/tb_mcu_interrupt_controller.sv
// Self-checking bench of the interrupt controller.
`timescale 1ns/1ps
`include "micint_defines.svh"
module tb_mcu_interrupt_controller;
  import micint_pkg::*;
  logic            clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, d, w;
  logic [1:0]      pa, pb;
  logic [4:0]      src;
  logic [5:0]      cmd;
  logic [15:0]     pc, pcv;
  logic [7:0]      acc, st, acc_o, st_o, rdata, sp0;
  logic            busy, pc_load, af_load, gen, memv, irq;
  micint_mem_req_t mreq;
  int              error_cnt, num_checks, m, i;
  ////////////////////////////////////////////////////////////////////////////////
  micint_top dut (
    .i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .i_ext_a_pins(pa), .i_ext_b_pins(pb),
    .i_ext_line_a_pin_option(1'b1), .i_ext_line_b_pin_option(1'b0),
    .i_wide_timer_evt(src[0]), .i_second_timer_evt(src[1]), .i_third_timer_evt(src[2]),
    .i_analog_comparator_evt(src[3]), .i_adc_evt(src[4]), .i_instr_boundary(cmd[0]),
    .i_pc(pc), .i_engint(cmd[1]), .i_disgint(cmd[2]), .i_reti(cmd[3]), .i_pushaf(cmd[4]),
    .i_popaf(cmd[5]), .i_accumulator(acc), .i_status(st), .o_busy(busy),
    .o_pc_load(pc_load), .o_pc_value(pcv), .o_af_load(af_load), .o_accumulator(acc_o),
    .o_status(st_o), .o_global_en(gen), .o_mem(mreq), .o_mem_valid(memv),
    .i_mem_rdata(rdata), .o_irq(irq));
  micint_mem_model u_mem (.i_core_clk(clk), .i_mem(mreq), .i_mem_valid(memv), .o_rdata(rdata));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= v;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    cmd[b] <= 1'b1;
    @(posedge clk);
    cmd <= '0;
    @(negedge clk);
  endtask
  task automatic lines(input logic v);
    @(posedge clk);
    pa  <= {v, ~v};
    pb  <= {~v, v};
    src <= {5{v}};
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_load(input logic af);
    int n;
    n = 0;
    while ((af ? af_load : pc_load) !== 1'b1 && n < 9) begin
      @(negedge clk);
      n++;
    end
    chk("load pulse", 1, af ? af_load : pc_load);
  endtask
  task automatic idle();
    while (busy !== 1'b0) @(negedge clk);
  endtask
  function automatic logic [31:0] exp_flags(input int mode, input logic rise);
    return ((rise && mode != 1) || (!rise && mode != 0)) ? 32'h7F : 32'h0;
  endfunction
  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, src, cmd, pc, acc, st} = '0;
    pa = 2'h1;
    pb = 2'h2;
    error_cnt = 0;
    num_checks = 0;
    void'($urandom(97));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      if (i < 7) chk("reset value", 32'h0, d);
      chk("slave error", {31'h0, i == 7}, {31'h0, e});
    end
    for (m = 0; m < 3; m++) begin
      apb(1'b1, `MICINT_ADDR_EDGE, {18'h0, {7{m[1:0]}}});
      for (i = 0; i < 2; i++) begin
        apb(1'b1, `MICINT_ADDR_FLAG, 32'h0);
        lines(i == 0);
        apb(1'b0, `MICINT_ADDR_FLAG, 32'h0);
        chk("flags", exp_flags(m, i == 0), d);
      end
    end
    lines(1'b1);
    w = $urandom;
    apb(1'b1, `MICINT_ADDR_FLAG, w);
    apb(1'b0, `MICINT_ADDR_FLAG, 32'h0);
    chk("flags after clear", {25'h0, w[6:0]}, d);
    lines(1'b0);
    sp0 = 8'($urandom) & 8'hF8;
    pc  <= 16'($urandom);
    acc <= 8'($urandom);
    st  <= 8'($urandom);
    apb(1'b1, `MICINT_ADDR_SP, {24'h0, sp0});
    pulse(1);
    chk("global enable", 1, gen);
    pulse(0);
    chk("busy", 0, busy);
    apb(1'b1, `MICINT_ADDR_EN, 32'h4);
    pulse(2);
    pulse(0);
    chk("busy", 0, busy);
    pulse(1);
    pulse(0);
    chk("busy", 1, busy);
    wait_load(1'b0);
    chk("vector", `MICINT_VECTOR, pcv);
    idle();
    chk("saved low pc", pc[7:0], u_mem.mem[sp0]);
    chk("saved high pc", pc[15:8], u_mem.mem[sp0 + 8'h1]);
    chk("global enable", 0, gen);
    apb(1'b0, `MICINT_ADDR_SP, 32'h0);
    chk("stack ptr", sp0 + 8'h2, d);
    apb(1'b1, `MICINT_ADDR_FLAG, ~32'h4);
    apb(1'b0, `MICINT_ADDR_FLAG, 32'h0);
    chk("flags after service", 32'h7B, d);
    @(negedge clk);
    chk("irq masked", 0, irq);
    apb(1'b1, `MICINT_ADDR_IMSK, 32'h1);
    @(negedge clk);
    chk("irq", 1, irq);
    apb(1'b0, `MICINT_ADDR_IST, 32'h0);
    chk("event status", 1, d);
    @(negedge clk);
    chk("irq cleared", 0, irq);
    pulse(4);
    idle();
    chk("saved acc", acc, u_mem.mem[sp0 + 8'h2]);
    chk("saved status", st, u_mem.mem[sp0 + 8'h3]);
    acc <= ~acc;
    pulse(5);
    wait_load(1'b1);
    chk("restored acc", 8'(~acc), acc_o);
    chk("restored status", st, st_o);
    idle();
    pulse(3);
    wait_load(1'b0);
    chk("return pc", pc, pcv);
    idle();
    chk("global enable", 1, gen);
    apb(1'b0, `MICINT_ADDR_SP, 32'h0);
    chk("stack ptr", sp0, d);
    apb(1'b0, `MICINT_ADDR_IST, 32'h0);
    chk("event status", 2, d);
    conclude();
  end
endmodule
